// ---- verilog/tcdu_top.sv ----
// tcdu_top.sv: two-wire cpu debug unit, device side
// assumes core strobes on sys_clk; pins are asynchronous
//
// Operation
// - data pin carries both shift data and tap state control
// - shift states sample the data pin on the clock's falling edge
// - key shifted while reset pin low; interface enabled at release
// - entry clock and data share the serial debug pins
// - only the exact 32-bit key enables two-wire debug
// - instrumentation off bit set disables, clear enables; trap opcode and trigger hits still raise halt request while set
// - entry holds cpu and watchdog in reset until halt request on
// - status shifts out while an instruction shifts in
// - read pc returns pc; short mode gives only low 16 bits
// - halt request on raises halt request; ack visible in status
// - halt request off drops halt request; ack visible likewise
// - user step pulses step until first fetch, one instruction
// - debugger step feeds instructions written to result register
// - program write on/off redirects data writes to program space
// - trap opcode puts core in debug mode with halt acknowledge
// - triggers halt on single address or address range match
// - accumulator reads come back via result with no-op
// - each change of flow stores old last pc and new first pc
// - serial clock is asynchronous; crossings are synchronised
`timescale 1ns/1ns
`include "tcdu_consts.svh"
module tcdu_top #(
   parameter logic [31:0] ENTRY_KEY = 32'h5A5A_0F0F // arbitrary value
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        reset_pin_b,
   input  wire logic        entry_clock_pin,
   input  wire logic        entry_data_in,
   output      logic        entry_data_out,
   output      logic        entry_data_oe_b,
   input  wire logic        instrumentation_off_bit,
   input  wire logic        halt_acknowledge,
   input  wire logic        short_counter_mode,
   input  wire logic [23:0] cpu_pc,
   input  wire logic        cpu_fetch_done,
   input  wire logic        cpu_cof,
   input  wire logic        cpu_exec,
   input  wire logic [7:0]  cpu_opcode,
   input  wire logic [7:0]  cpu_acc,
   input  wire logic        bus_valid,
   input  wire logic [23:0] bus_addr,
   output      logic        two_wire_enabled,
   output      logic        debug_hold_reset,
   output      logic        halt_request,
   output      logic        single_step_pulse,
   output      logic        fed_instr_mode,
   output      logic [7:0]  fed_instr,
   output      logic        prog_write_redirect
);
   import tcdu_pkg::*;

   //--------------------------------------------------
   // state and helpers
   //--------------------------------------------------
   tcdu_st_t    s_r;
   tcdu_st_t    s_nxt;
   logic        trc_pop;
   logic [47:0] trc_head;
   logic        trc_empty;
   logic        ck_rise;
   logic        ck_fall;
   logic        rp_rise;
   logic [47:0] shin;
   logic [47:0] din;
   logic [23:0] pc_view;
   logic [3:0]  status;
   logic        trg_hit;

   // edges seen on the second synchroniser stage
   assign ck_rise = s_r.tck_s2 & ~s_r.tck_s3;
   assign ck_fall = ~s_r.tck_s2 & s_r.tck_s3;
   assign rp_rise = s_r.rsp_s2 & ~s_r.rsp_s3;

   // pc as seen by the debugger
   assign pc_view = short_counter_mode ? {8'h00, cpu_pc[15:0]}
                                       : cpu_pc;

   // status word shifted out with each instruction
   assign status = {halt_acknowledge, s_r.hreq,
                    s_r.dstep | s_r.ustep, s_r.pswr};

   // shift register after one more incoming bit
   assign shin = {s_r.dio_s2, s_r.sh[47:1]};

   // received value right aligned
   assign din = shin >> (`TCDU_SH_W - s_r.len);

   // single or range trigger on bus addresses
   always_comb
   begin
      trg_hit = 1'b0;
      case (s_r.trg_mode)
         `TCDU_TM_SINGLE: trg_hit = bus_addr == s_r.trg_lo;
         `TCDU_TM_RANGE:  trg_hit = bus_addr >= s_r.trg_lo &&
                                    bus_addr <= s_r.trg_hi;
         default:         trg_hit = 1'b0;
      endcase
   end

   // trace read pops the oldest record at dr load
   assign trc_pop = s_r.enabled && s_r.tap == TAP_SEL && ck_rise &&
                    s_r.dio_s2 && s_r.instr == `TCDU_I_TRACE;

   //--------------------------------------------------
   // trace buffer
   //--------------------------------------------------
   tcdu_trace u_trace (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .fetch   (cpu_fetch_done),
      .cof     (cpu_cof),
      .pc      (cpu_pc),
      .pop     (trc_pop),
      .head    (trc_head),
      .empty   (trc_empty)
   );

   //--------------------------------------------------
   // next state
   //--------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      // two-flop synchronisers on the pins
      s_nxt.tck_s1 = entry_clock_pin;
      s_nxt.tck_s2 = s_r.tck_s1;
      s_nxt.tck_s3 = s_r.tck_s2;
      s_nxt.dio_s1 = entry_data_in;
      s_nxt.dio_s2 = s_r.dio_s1;
      s_nxt.rsp_s1 = reset_pin_b;
      s_nxt.rsp_s2 = s_r.rsp_s1;
      s_nxt.rsp_s3 = s_r.rsp_s2;

      // entry key shifted on the shared pins under reset
      if (!s_r.rsp_s2)
      begin
         s_nxt.enabled = 1'b0;
         s_nxt.tap     = TAP_IDLE;
         s_nxt.oe_b    = 1'b1;
         if (ck_rise)
         begin
            s_nxt.key = {s_r.key[30:0], s_r.dio_s2};
         end
      end
      else if (rp_rise)
      begin
         s_nxt.enabled  = s_r.key == ENTRY_KEY;
         s_nxt.hold_rst = s_r.key == ENTRY_KEY;
         s_nxt.key      = `TCDU_KEY_RST;
      end
      else if (s_r.enabled)
      begin
         case (s_r.tap)
            // control bit sampled on rising edge
            TAP_IDLE:
            begin
               if (ck_rise && s_r.dio_s2)
               begin
                  s_nxt.tap = TAP_SEL;
               end
            end
            // choose instruction or data shift
            TAP_SEL:
            begin
               if (ck_rise)
               begin
                  s_nxt.arm = 1'b0;
                  if (!s_r.dio_s2)
                  begin
                     s_nxt.tap = TAP_SHIR;
                     s_nxt.len = `TCDU_IR_LEN;
                     s_nxt.sh  = {44'h0, status};
                  end
                  else
                  begin
                     s_nxt.tap = TAP_SHDR;
                     case (s_r.instr)
                        `TCDU_I_READ_PROGRAM_COUNTER_INSTR:
                        begin
                           s_nxt.len = `TCDU_PC_LEN;
                           s_nxt.sh  = {24'h0, pc_view};
                        end
                        `TCDU_I_TRACE:
                        begin
                           s_nxt.len = `TCDU_TRC_LEN;
                           s_nxt.sh  = trc_empty ? `TCDU_SH_RST
                                                 : trc_head;
                        end
                        `TCDU_I_TRG_LO, `TCDU_I_TRG_HI:
                        begin
                           s_nxt.len = `TCDU_PC_LEN;
                           s_nxt.sh  = `TCDU_SH_RST;
                        end
                        default:
                        begin
                           s_nxt.len = `TCDU_RES_LEN;
                           s_nxt.sh  = {39'h0, ~halt_acknowledge,
                                        s_r.result};
                        end
                     endcase
                  end
                  s_nxt.cnt = s_nxt.len;
               end
            end
            // data sampled on falling edge
            TAP_SHIR, TAP_SHDR:
            begin
               if (ck_rise && s_r.arm)
               begin
                  s_nxt.oe_b = 1'b1;
               end
               if (ck_fall && !s_r.arm)
               begin
                  s_nxt.arm  = 1'b1;
                  s_nxt.dout = s_r.sh[0];
                  s_nxt.oe_b = 1'b0;
               end
               else if (ck_fall)
               begin
                  s_nxt.sh  = shin;
                  s_nxt.cnt = s_r.cnt - 6'd1;
                  s_nxt.dout = s_r.sh[1];
                  s_nxt.oe_b = 1'b0;
                  if (s_r.cnt == 6'd1)
                  begin
                     s_nxt.oe_b = 1'b1;
                     s_nxt.tap  = TAP_IDLE;
                  end
               end
               // instruction update
               if (ck_fall && s_r.arm && s_r.cnt == 6'd1 &&
                   s_r.tap == TAP_SHIR && !instrumentation_off_bit)
               begin
                  s_nxt.instr = din[3:0];
                  case (din[3:0])
                     `TCDU_I_NOOP:
                        s_nxt.result = cpu_acc;
                     `TCDU_I_HRQ_ON:
                     begin
                        s_nxt.hreq     = 1'b1;
                        s_nxt.hold_rst = 1'b0;
                     end
                     `TCDU_I_HRQ_OFF:
                     begin
                        s_nxt.hreq  = 1'b0;
                        s_nxt.ustep = 1'b0;
                        s_nxt.dstep = 1'b0;
                     end
                     `TCDU_I_USTEP:
                     begin
                        s_nxt.ustep = 1'b1;
                        s_nxt.dstep = 1'b0;
                     end
                     `TCDU_I_DSTEP:
                     begin
                        s_nxt.dstep = 1'b1;
                        s_nxt.ustep = 1'b0;
                     end
                     `TCDU_I_PSW_ON:  s_nxt.pswr = 1'b1;
                     `TCDU_I_PSW_OFF: s_nxt.pswr = 1'b0;
                     `TCDU_I_TRG_OFF:
                        s_nxt.trg_mode = `TCDU_TM_OFF;
                     default: s_nxt.result = s_r.result;
                  endcase
               end
               // data update
               if (ck_fall && s_r.arm && s_r.cnt == 6'd1 &&
                   s_r.tap == TAP_SHDR && !instrumentation_off_bit)
               begin
                  case (s_r.instr)
                     `TCDU_I_DSTEP:
                     begin
                        s_nxt.result = din[7:0];
                        s_nxt.fed    = din[7:0];
                        s_nxt.step   = halt_acknowledge;
                     end
                     `TCDU_I_USTEP:
                        s_nxt.step = halt_acknowledge;
                     `TCDU_I_TRG_LO:
                     begin
                        s_nxt.trg_lo   = din[23:0];
                        s_nxt.trg_mode = `TCDU_TM_SINGLE;
                     end
                     `TCDU_I_TRG_HI:
                     begin
                        s_nxt.trg_hi   = din[23:0];
                        s_nxt.trg_mode = `TCDU_TM_RANGE;
                     end
                     default: s_nxt.step = s_r.step;
                  endcase
               end
            end
            default: s_nxt.tap = TAP_IDLE;
         endcase
      end

      // step held until the first fetch completes
      if (s_r.step && cpu_fetch_done)
      begin
         s_nxt.step = 1'b0;
      end

      // trap opcode and trigger hits stop the core, set wins
      if (s_r.enabled && cpu_exec && cpu_opcode == `TCDU_TRAP_OP)
      begin
         s_nxt.hreq = 1'b1;
      end
      if (s_r.enabled && bus_valid && trg_hit)
      begin
         s_nxt.hreq = 1'b1;
      end
   end

   //--------------------------------------------------
   // state register
   //--------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_r      <= '0;
         s_r.tap  <= TAP_IDLE;
         s_r.oe_b <= 1'b1;
         // pin idles high: no false release edge after reset
         s_r.rsp_s1 <= 1'b1;
         s_r.rsp_s2 <= 1'b1;
         s_r.rsp_s3 <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   //--------------------------------------------------
   // outputs straight from state
   //--------------------------------------------------
   assign entry_data_out      = s_r.dout;
   assign entry_data_oe_b     = s_r.oe_b;
   assign two_wire_enabled    = s_r.enabled;
   assign debug_hold_reset    = s_r.hold_rst;
   assign halt_request        = s_r.hreq;
   assign single_step_pulse   = s_r.step;
   assign fed_instr_mode      = s_r.dstep;
   assign fed_instr           = s_r.fed;
   assign prog_write_redirect = s_r.pswr;
endmodule // tcdu_top

// ---- verilog/tcdu_consts.svh ----
// tcdu_consts.svh: constants of the two-wire cpu debug unit
// assumes inclusion by bare name from the package and modules
`ifndef TCDU_CONSTS_SVH
`define TCDU_CONSTS_SVH
// shift lengths per debug instruction
`define TCDU_IR_LEN    6'd4
`define TCDU_RES_LEN   6'd9
`define TCDU_PC_LEN    6'd24
`define TCDU_TRC_LEN   6'd48
`define TCDU_SH_W      6'd48
// debug instruction codes
`define TCDU_I_NOOP    4'h0
`define TCDU_I_HRQ_ON  4'h1
`define TCDU_I_HRQ_OFF 4'h2
`define TCDU_I_USTEP   4'h3
`define TCDU_I_DSTEP   4'h4
`define TCDU_I_PSW_ON  4'h5
`define TCDU_I_PSW_OFF 4'h6
`define TCDU_I_READ_PROGRAM_COUNTER_INSTR  4'h7
`define TCDU_I_TRG_LO  4'h8
`define TCDU_I_TRG_HI  4'h9
`define TCDU_I_TRG_OFF 4'hA
`define TCDU_I_TRACE   4'hB
// trigger modes
`define TCDU_TM_OFF    2'h0
`define TCDU_TM_SINGLE 2'h1
`define TCDU_TM_RANGE  2'h2
// breakpoint trap opcode
`define TCDU_TRAP_OP   8'hA5
// trace buffer depth and full record count
`define TCDU_TRC_DEPTH 8
`define TCDU_TRC_FULL  4'h8
// reset values
`define TCDU_KEY_RST   32'h0
`define TCDU_SH_RST    48'h0
`endif

// ---- verilog/tcdu_pkg.sv ----
// tcdu_pkg.sv: types of the two-wire cpu debug unit
// assumes tcdu_consts.svh on the include path
`include "tcdu_consts.svh"
package tcdu_pkg;
   typedef enum logic [1:0] {
      TAP_IDLE, TAP_SEL, TAP_SHIR, TAP_SHDR
   } tcdu_tap_t;

   typedef struct packed {
      logic [`TCDU_TRC_DEPTH-1:0][47:0] mem;
      logic [2:0]  wr;
      logic [2:0]  rd;
      logic [3:0]  cnt;
      logic [23:0] last;
   } tcdu_trc_t;

   typedef struct packed {
      logic        tck_s1, tck_s2, tck_s3;
      logic        dio_s1, dio_s2;
      logic        rsp_s1, rsp_s2, rsp_s3;
      logic [31:0] key;
      logic        enabled;
      tcdu_tap_t   tap;
      logic        arm;
      logic [3:0]  instr;
      logic [47:0] sh;
      logic [5:0]  cnt;
      logic [5:0]  len;
      logic        dout;
      logic        oe_b;
      logic        hold_rst;
      logic        hreq;
      logic        ustep;
      logic        dstep;
      logic        step;
      logic [7:0]  fed;
      logic        pswr;
      logic [7:0]  result;
      logic [23:0] trg_lo;
      logic [23:0] trg_hi;
      logic [1:0]  trg_mode;
   } tcdu_st_t;
endpackage

// ---- verilog/tcdu_trace.sv ----
// tcdu_trace.sv: change-of-flow trace buffer
// assumes fetch and flow strobes from the core on sys_clk
`timescale 1ns/1ns
`include "tcdu_consts.svh"
module tcdu_trace (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        fetch,
   input  wire logic        cof,
   input  wire logic [23:0] pc,
   input  wire logic        pop,
   output      logic [47:0] head,
   output      logic        empty
);
   import tcdu_pkg::*;
   tcdu_trc_t tr_r;
   tcdu_trc_t tr_nxt;
   logic      push;
   logic      take;

   // oldest record and fill state
   assign head  = tr_r.mem[tr_r.rd];
   assign empty = (tr_r.cnt == 4'h0);

   // ring of records, oldest overwritten when full
   always_comb
   begin
      tr_nxt = tr_r;
      push   = fetch & cof;
      take   = pop & (tr_r.cnt != 4'h0);
      if (fetch)
      begin
         tr_nxt.last = pc;
      end
      if (push)
      begin
         tr_nxt.mem[tr_r.wr] = {tr_r.last, pc};
         tr_nxt.wr = tr_r.wr + 3'h1;
      end
      if (push && tr_r.cnt == `TCDU_TRC_FULL)
      begin
         tr_nxt.rd = tr_r.rd + 3'h1;
      end
      else if (push && !take)
      begin
         tr_nxt.cnt = tr_r.cnt + 4'h1;
      end
      else if (take && !push)
      begin
         tr_nxt.rd  = tr_r.rd + 3'h1;
         tr_nxt.cnt = tr_r.cnt - 4'h1;
      end
      else if (take)
      begin
         tr_nxt.rd = tr_r.rd + 3'h1;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tr_r <= '0;
      end
      else
      begin
         tr_r <= tr_nxt;
      end
   end
endmodule // tcdu_trace

// ---- testbench/tcdu_probe.sv ----
// tcdu_probe.sv: debugger model on the two-wire link
// assumes sys_clk from the bench; link half period is 10 cycles
`timescale 1ns/1ns
module tcdu_probe (
   input  wire logic sys_clk,
   input  wire logic dev_out,
   input  wire logic dev_oe_b,
   output logic      sclk,
   output logic      rst_pin_b,
   output logic      line
);
   logic hval;
   logic hdrv;
   // device wins, else host, else inverse of last host value
   assign line = !dev_oe_b ? dev_out : (hdrv ? hval : ~hval);
   initial
   begin
      sclk = 1'b0;
      rst_pin_b = 1'b1;
      hval = 1'b1;
      hdrv = 1'b0;
   end
   // one half period; host releases 3 cycles after a fall
   task automatic tick(input logic c, input logic d, output logic s);
      @(posedge sys_clk);
      s = line;
      sclk <= c;
      hval <= d;
      if (c)
         hdrv <= 1'b1;
      repeat (3) @(posedge sys_clk);
      hdrv <= c;
      repeat (6) @(posedge sys_clk);
   endtask
   // key msb first while the reset pin is low
   task automatic key(input logic [31:0] k);
      logic s;
      @(posedge sys_clk);
      rst_pin_b <= 1'b0;
      repeat (6) @(posedge sys_clk);
      for (int i = 31; i >= 0; i--)
      begin
         tick(1'b1, k[i], s);
         tick(1'b0, k[i], s);
      end
      rst_pin_b <= 1'b1;
      repeat (10) @(posedge sys_clk);
   endtask
   // select, register choice, arming fall, then n bits lsb first
   task automatic frame(input logic dr, input int n,
                        input logic [47:0] din, output logic [47:0] dout);
      logic s;
      dout = '0;
      tick(1'b1, 1'b1, s);
      tick(1'b0, 1'b1, s);
      tick(1'b1, dr, s);
      tick(1'b0, dr, s);
      for (int k = 0; k < n; k++)
      begin
         tick(1'b1, din[k], s);
         dout[k] = s;
         tick(1'b0, din[k], s);
      end
      repeat (10) @(posedge sys_clk);
   endtask
endmodule // tcdu_probe

// ---- testbench/tcdu_top_sva.sv ----
// tcdu_top_sva.sv: port checks of the two-wire debug unit
// assumes binding to tcdu_top, everything on sys_clk
`timescale 1ns/1ns
module tcdu_top_sva (
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic       reset_pin_b,
   input wire logic       entry_clock_pin,
   input wire logic       entry_data_oe_b,
   input wire logic       instrumentation_off_bit,
   input wire logic       halt_acknowledge,
   input wire logic       cpu_fetch_done,
   input wire logic       cpu_exec,
   input wire logic [7:0] cpu_opcode,
   input wire logic       two_wire_enabled,
   input wire logic       debug_hold_reset,
   input wire logic       halt_request,
   input wire logic       single_step_pulse,
   input wire logic       fed_instr_mode
);
   // ----------
   // checks
   // ----------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   pin_drop_a: assert property (
      $fell(reset_pin_b) |-> ##[1:8] !two_wire_enabled)
      else $error("enable outlived reset pin");
   entry_hold_a: assert property (
      $rose(two_wire_enabled) |-> reset_pin_b && debug_hold_reset)
      else $error("entry without pin release or hold");
   hold_free_a: assert property (
      $fell(debug_hold_reset) && two_wire_enabled |-> halt_request)
      else $error("hold released without halt request");
   key_drive_a: assert property (
      !entry_data_oe_b |-> two_wire_enabled)
      else $error("data pin driven while disabled");
   rise_release_a: assert property (
      $rose(entry_clock_pin) |-> ##[1:8] entry_data_oe_b)
      else $error("data pin not released after rise");
   trap_halt_a: assert property (
      cpu_exec && cpu_opcode == 8'hA5 && two_wire_enabled
      && !instrumentation_off_bit |=> halt_request)
      else $error("trap did not raise halt request");
   step_end_a: assert property (
      single_step_pulse && cpu_fetch_done |=> !single_step_pulse)
      else $error("step outlived fetch");
   step_ack_a: assert property (
      $rose(single_step_pulse) |-> $past(halt_acknowledge))
      else $error("step without halt acknowledge");
   fed_mode_a: assert property (
      $rose(fed_instr_mode) |-> two_wire_enabled)
      else $error("fed mode while disabled");
   cov_entry: cover property ($rose(two_wire_enabled));
   cov_step: cover property ($rose(single_step_pulse));
   cov_halt: cover property ($rose(halt_request));
endmodule // tcdu_top_sva
bind tcdu_top tcdu_top_sva u_sva (
   .sys_clk(sys_clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
   .entry_clock_pin(entry_clock_pin), .entry_data_oe_b(entry_data_oe_b),
   .instrumentation_off_bit(instrumentation_off_bit),
   .halt_acknowledge(halt_acknowledge), .cpu_fetch_done(cpu_fetch_done),
   .cpu_exec(cpu_exec), .cpu_opcode(cpu_opcode),
   .two_wire_enabled(two_wire_enabled), .debug_hold_reset(debug_hold_reset),
   .halt_request(halt_request), .single_step_pulse(single_step_pulse),
   .fed_instr_mode(fed_instr_mode)
);

// ---- testbench/tb_two_wire_cpu_debug_unit.sv ----
// tb_two_wire_cpu_debug_unit.sv: self-checking bench of the debug unit
// assumes tcdu_top, tcdu_probe and the checker compiled first
`timescale 1ns/1ns
module tb_two_wire_cpu_debug_unit;
   localparam logic [31:0] KEY = 32'h5A5A_0F0F; // arbitrary value
   logic        sys_clk, rst_b, rst_pin_b, sclk, line, dout, oe_b;
   logic        off, ack, short_md, fetch, cof, exec, bv;
   logic [23:0] pc, ba;
   logic [7:0]  op, acc, fi;
   logic        en, hold, hreq, step, fmode, pswr;
   logic [3:0]  st;
   logic [47:0] o;
   int          error_cnt, compares, cyc;
   tcdu_top #(.ENTRY_KEY(KEY)) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .reset_pin_b(rst_pin_b),
      .entry_clock_pin(sclk), .entry_data_in(line),
      .entry_data_out(dout), .entry_data_oe_b(oe_b),
      .instrumentation_off_bit(off), .halt_acknowledge(ack),
      .short_counter_mode(short_md), .cpu_pc(pc), .cpu_fetch_done(fetch),
      .cpu_cof(cof), .cpu_exec(exec), .cpu_opcode(op), .cpu_acc(acc),
      .bus_valid(bv), .bus_addr(ba), .two_wire_enabled(en),
      .debug_hold_reset(hold), .halt_request(hreq),
      .single_step_pulse(step), .fed_instr_mode(fmode), .fed_instr(fi),
      .prog_write_redirect(pswr));
   tcdu_probe dbg (.sys_clk(sys_clk), .dev_out(dout), .dev_oe_b(oe_b),
      .sclk(sclk), .rst_pin_b(rst_pin_b), .line(line));
   // clock and a core that acknowledges halts, not during a step
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
      ack <= hreq && !step;
   // hang limit
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ir(input logic [3:0] c);
      dbg.frame(1'b0, 4, {44'h0, c}, o);
      st = o[3:0];
   endtask
   task automatic pulse(input logic [23:0] a, input logic c, input logic b);
      @(posedge sys_clk);
      pc <= a;
      fetch <= !b;
      cof <= c;
      bv <= b;
      ba <= a;
      @(posedge sys_clk);
      fetch <= 1'b0;
      bv <= 1'b0;
      @(posedge sys_clk);
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_entry();
      dbg.key(~KEY);
      chk(en, 0);
      dbg.key(KEY);
      chk({en, hold}, 2'b11);
      $display("test entry done");
   endtask
   task automatic t_halt();
      ir(4'h1);
      chk({hold, hreq}, 2'b01);
      ir(4'h0);
      chk(st, 4'hC);
      dbg.frame(1'b1, 9, 48'h0, o);
      chk(o[8:0], 9'h03C);
      ir(4'h2);
      chk(hreq, 0);
      ir(4'h0);
      chk(st, 4'h0);
      dbg.frame(1'b1, 9, 48'h0, o);
      chk(o[8:0], 9'h13C);
      $display("test halt done");
   endtask
   task automatic t_pswr_pc();
      ir(4'h5);
      chk(pswr, 1);
      ir(4'h6);
      chk({st, pswr}, 5'h02);
      short_md <= 1'b1;
      pc <= 24'hABCDEF;
      ir(4'h7);
      dbg.frame(1'b1, 24, 48'h0, o);
      chk(o[23:0], 24'h00CDEF);
      short_md <= 1'b0;
      ir(4'h7);
      dbg.frame(1'b1, 24, 48'h0, o);
      chk(o[23:0], 24'hABCDEF);
      off <= 1'b1;
      ir(4'h1);
      chk(hreq, 0);
      off <= 1'b0;
      $display("test pswr pc off done");
   endtask
   task automatic t_trap_step();
      @(posedge sys_clk);
      exec <= 1'b1;
      op <= 8'hA5;
      @(posedge sys_clk);
      exec <= 1'b0;
      @(posedge sys_clk);
      chk(hreq, 1);
      for (int i = 0; i < 4 && st[3] !== 1'b1; i++)
         ir(4'h0);
      chk(st[3], 1);
      ir(4'h4);
      chk(fmode, 1);
      dbg.frame(1'b1, 9, 48'h0E4, o);
      chk({fi, step, o[8:0]}, {8'hE4, 1'b1, 9'h03C});
      pulse(24'h000040, 1'b0, 1'b0);
      ir(4'h3);
      dbg.frame(1'b1, 9, 48'h0, o);
      chk({fmode, step, o[8:0]}, {2'b01, 9'h0E4});
      pulse(24'h000050, 1'b0, 1'b0);
      chk(step, 0);
      $display("test trap step done");
   endtask
   task automatic t_trace_trig();
      for (int k = 0; k < 9; k++)
      begin
         pulse(24'(k), 1'b0, 1'b0);
         pulse(24'h100 + 24'(k), 1'b1, 1'b0);
      end
      ir(4'hB);
      dbg.frame(1'b1, 48, 48'h0, o);
      chk(o, {24'h1, 24'h101});
      ir(4'h2);
      ir(4'h8);
      dbg.frame(1'b1, 24, 48'h1234, o);
      pulse(24'h001234, 1'b0, 1'b1);
      chk(hreq, 1);
      ir(4'h2);
      ir(4'h9);
      dbg.frame(1'b1, 24, 48'h2000, o);
      pulse(24'h001100, 1'b0, 1'b1);
      chk(hreq, 0);
      pulse(24'h001800, 1'b0, 1'b1);
      chk(hreq, 1);
      dbg.key(~KEY);
      chk(en, 0);
      $display("test trace trigger done");
   endtask
   task automatic print_verdict();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      {rst_b, off, short_md, fetch, cof, exec, bv} = '0;
      {pc, ba, op, st} = '0;
      acc = 8'h3C;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_entry();
      t_halt();
      t_pswr_pc();
      t_trap_step();
      t_trace_trig();
      print_verdict();
   end
endmodule // tb_two_wire_cpu_debug_unit
